// ---- inc/lpi_pkg.sv ----
// constants shared by the pwm intensity block
package lpi_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_OUT = 9;
	localparam int NUM_OUT_REG = 4;
	localparam logic [7:0] ADDR_MASTER = 8'h0e;
	localparam logic [7:0] ADDR_OUT0 = 8'h10;
	localparam logic [7:0] ADDR_OUT3 = 8'h13;
	localparam logic [7:0] RST_MASTER = 8'h00;
	localparam logic [7:0] RST_OUT = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	localparam int MASTER_MSB = 7;
	localparam int MASTER_LSB = 4;
	localparam int GLOBAL_MSB = 3;
	localparam int GLOBAL_LSB = 0;
	localparam logic [3:0] SET_STATIC = 4'hf;
	localparam logic [3:0] MASTER_OFF = 4'h0;
	localparam logic [3:0] SLOT_LAST = 4'he;
	localparam logic [3:0] CYC_LAST = 4'hf;
	localparam int CLK_PERIOD_NS = 10;
	localparam int PWM_STEP_NS = 31250;
	localparam int STEP_CYC = PWM_STEP_NS / CLK_PERIOD_NS;
	localparam int STEP_W = 12;
	typedef logic [3:0] lpi_nib_t;
endpackage

// ---- inc/lpi_tick_if.sv ----
// pwm step and position carrier from timebase to output logic
`timescale 1ns/10ps
interface lpi_tick_if;
	logic step;
	logic [3:0] cyc;
	logic [3:0] slot;
	modport src (output step, output cyc, output slot);
	modport dst (input step, input cyc, input slot);
endinterface

// ---- src/lpi_timebase.sv ----
// pwm step divider and 15 x 16 step position counters
`timescale 1ns/10ps
module lpi_timebase
	import lpi_pkg::*;
#(
	parameter int STEP_COUNT = STEP_CYC
)
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// control
	input wire logic i_run,
	// position out
	lpi_tick_if.src tk
);
	logic [STEP_W-1:0] div_r;
	localparam logic [STEP_W-1:0] DIV_LAST = STEP_W'(STEP_COUNT - 1);

	////////////////////////////////////////////////////////////////
	// divider held at zero while stopped, so it costs nothing when static
	always_ff @(posedge i_mclk)
	begin
		if (i_srst || !i_run || div_r == DIV_LAST)
			div_r <= '0;
		else
			div_r <= div_r + 1'b1;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst || !i_run)
			tk.step <= 1'b0;
		else
			tk.step <= (div_r == DIV_LAST);
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst || !i_run)
		begin
			tk.cyc <= '0;
			tk.slot <= '0;
		end
		else if (tk.step)
		begin
			tk.cyc <= tk.cyc + 1'b1;
			if (tk.cyc == CYC_LAST)
				tk.slot <= (tk.slot == SLOT_LAST) ? 4'h0 : tk.slot + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	slot_range_a: assert property (@(posedge i_mclk) disable iff (i_srst) tk.slot <= SLOT_LAST)
		else $error("slot index beyond last timeslot");
	slot_wrap_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(i_run && tk.step && tk.cyc == CYC_LAST && tk.slot == SLOT_LAST) |=> (i_run -> tk.slot == 4'h0))
		else $error("period did not close after 240 steps");
endmodule

// ---- src/lpi_out_cell.sv ----
// level decision for one open-drain output
`timescale 1ns/10ps
module lpi_out_cell
	import lpi_pkg::*;
(
	// setting and state
	input wire lpi_nib_t i_setting,
	input wire logic i_level,
	input wire logic i_static_all,
	input wire logic i_gated,
	input wire logic [3:0] i_cyc,
	// decision
	output logic o_drive_low
);
	always_comb
	begin
		if (i_static_all || i_setting == SET_STATIC)
			o_drive_low = ~i_level;
		else if (i_gated && i_cyc <= i_setting)
			o_drive_low = ~i_level;
		else
			o_drive_low = i_level;
	end
endmodule

// ---- src/lpi_intensity.sv ----
// pwm intensity registers and nine open-drain output drivers
`timescale 1ns/10ps
//
// Operation
// - master field zero: all outputs static, global flag and output settings unused.
// - global flag is ignored while master field selects all static.
// - nonzero master, global clear: first eight outputs use their own 4-bit setting, ninth uses master low nibble.
// - individual setting 0xf gives a static glitch-free output.
// - individual setting 0x0 to 0xe gives pwm per that setting.
// - global set, master nonzero: all outputs use low nibble of master register.
// - global mode consults only the master register, never the output registers.
// - level 0, setting n: low (n+1)/16, released (15-n)/16 per gated slot.
// - level 1, setting n: low (15-n)/16, released (n+1)/16 per gated slot.
// - setting 0xf: static low for level 0, static released for level 1.
// - period of 240 steps: 15 timeslots of 16 pwm cycles each.
// - master field gates modulation to 1 through 15 timeslots per period.
// - 16/16 setting ignores master gating and follows the level bit.
// - master field in upper four bits, ninth output/global field in lower four.
module lpi_intensity
	import lpi_pkg::*;
#(
	parameter int STEP_COUNT = STEP_CYC,
	parameter int OUT_N = NUM_OUT
)
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// register port
	input wire logic i_wr_en,
	input wire logic [lpi_pkg::ADDR_W-1:0] i_wr_addr,
	input wire logic [lpi_pkg::DATA_W-1:0] i_wr_data,
	input wire logic i_rd_en,
	input wire logic [lpi_pkg::ADDR_W-1:0] i_rd_addr,
	output logic [lpi_pkg::DATA_W-1:0] o_rd_data,
	// configuration from outside the block
	input wire logic i_global_en,
	input wire logic [OUT_N-1:0] i_level,
	// open-drain pins
	output logic [OUT_N-1:0] o_port_o,
	output logic [OUT_N-1:0] o_port_oe,
	// status
	output logic o_pwm_run
);
	import lpi_pkg::*;

	logic [7:0] master_r;
	logic [7:0] outint_r [0:NUM_OUT_REG-1];
	lpi_nib_t sel_w [0:OUT_N-1];
	logic [OUT_N-1:0] drive_w;
	logic run_w;
	logic static_all_w;
	logic global_w;
	logic gated_w;
	lpi_nib_t master_f;
	lpi_nib_t global_f;

	lpi_tick_if tk ();

	////////////////////////////////////////////////////////////////
	// address decode, shared by write and read
	function automatic logic is_out_addr(input logic [7:0] a);
		is_out_addr = (a >= ADDR_OUT0) && (a <= ADDR_OUT3);
	endfunction

	function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2, input logic [7:0] r3);
		logic [7:0] v;
		v = RD_UNMAPPED;
		if (a == ADDR_MASTER)
			v = m;
		else if (is_out_addr(a))
		begin
			case (a[1:0])
				2'h0: v = r0;
				2'h1: v = r1;
				2'h2: v = r2;
				2'h3: v = r3;
				default: v = RD_UNMAPPED;
			endcase
		end
		reg_read = v;
	endfunction

	////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
			master_r <= RST_MASTER;
		else if (i_wr_en && i_wr_addr == ADDR_MASTER)
			master_r <= i_wr_data;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			for (int i = 0; i < NUM_OUT_REG; i++)
				outint_r[i] <= RST_OUT;
		end
		else if (i_wr_en && is_out_addr(i_wr_addr))
			outint_r[i_wr_addr[1:0]] <= i_wr_data;
	end

	// unmapped reads answer zero rather than holding stale data
	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
			o_rd_data <= RD_UNMAPPED;
		else if (i_rd_en)
			o_rd_data <= reg_read(i_rd_addr, master_r, outint_r[0], outint_r[1], outint_r[2], outint_r[3]);
	end

	////////////////////////////////////////////////////////////////
	// mode decode
	assign master_f = master_r[MASTER_MSB:MASTER_LSB];
	assign global_f = master_r[GLOBAL_MSB:GLOBAL_LSB];
	assign static_all_w = (master_f == MASTER_OFF);
	assign run_w = ~static_all_w;
	assign global_w = i_global_en && run_w;
	assign gated_w = tk.slot < master_f;

	// two outputs per register, even output in the low nibble
	always_comb
	begin
		for (int k = 0; k < OUT_N; k++)
		begin
			if (global_w || k >= 2 * NUM_OUT_REG)
				sel_w[k] = global_f;
			else if (k[0])
				sel_w[k] = outint_r[k / 2][7:4];
			else
				sel_w[k] = outint_r[k / 2][3:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// timebase stops while all static, which also keeps it phase-aligned on restart
	lpi_timebase #(
		.STEP_COUNT(STEP_COUNT)
	) u_tb (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_run(run_w),
		.tk(tk)
	);

	for (genvar g = 0; g < OUT_N; g++)
	begin : g_cell
		lpi_out_cell u_cell (
			.i_setting(sel_w[g]),
			.i_level(i_level[g]),
			.i_static_all(static_all_w),
			.i_gated(gated_w),
			.i_cyc(tk.cyc),
			.o_drive_low(drive_w[g])
		);
	end

	////////////////////////////////////////////////////////////////
	// outputs; pin data is always zero, only the enable switches
	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
			o_port_oe <= '0;
		else
			o_port_oe <= drive_w;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
			o_port_o <= '0;
		else
			o_port_o <= '0;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
			o_pwm_run <= 1'b0;
		else
			o_pwm_run <= run_w;
	end

	////////////////////////////////////////////////////////////////
	static_all_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(master_f == MASTER_OFF) |=> (o_port_oe == ~$past(i_level)))
		else $error("static mode output does not follow level");
	global_ignored_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(static_all_w && i_global_en) |=> (o_port_oe == ~$past(i_level) && !o_pwm_run))
		else $error("global flag acted while all static");
	indiv_select_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(run_w && !i_global_en) |-> (sel_w[1] == outint_r[0][7:4] && sel_w[6] == outint_r[3][3:0]))
		else $error("individual setting not taken from own nibble");
	indiv_static_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(!global_w && outint_r[0][3:0] == SET_STATIC) |=> (o_port_oe[0] == ~$past(i_level[0])))
		else $error("setting 0xf output not static");
	global_select_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		global_w |-> (sel_w[0] == global_f && sel_w[7] == global_f))
		else $error("global mode setting not from master register");
	pwm_low_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(run_w && gated_w && sel_w[2] != SET_STATIC && tk.cyc <= sel_w[2] && !i_level[2])
		|=> o_port_oe[2])
		else $error("level 0 output not low in on-time");
	pwm_high_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(run_w && gated_w && sel_w[2] != SET_STATIC && tk.cyc > sel_w[2] && !i_level[2])
		|=> !o_port_oe[2])
		else $error("level 0 output low in off-time");
	inv_level_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(run_w && gated_w && sel_w[3] != SET_STATIC && tk.cyc > sel_w[3] && i_level[3])
		|=> o_port_oe[3])
		else $error("level 1 output not low in off-time");
	gate_off_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(run_w && !gated_w && sel_w[8] != SET_STATIC) |=> (o_port_oe[8] == $past(i_level[8])))
		else $error("output modulated outside gated slots");
	pin_zero_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		o_port_o == '0)
		else $error("pin data not zero");
	read_back_a: assert property (@(posedge i_mclk) disable iff (i_srst)
		(i_rd_en && i_rd_addr == ADDR_MASTER && !(i_wr_en && i_wr_addr == ADDR_MASTER))
		|=> (o_rd_data == master_r))
		else $error("master register read back wrong");
endmodule

// ---- verif/lpi_pullup_load.sv ----
// pullup load model standing on the nine open-drain pins
`timescale 1ns/10ps
module lpi_pullup_load
(
	// pin drivers
	input wire logic [8:0] i_oe,
	input wire logic [8:0] i_o,
	// resolved levels
	output logic [8:0] o_pin
);
	// released pin floats up to the pullup, never keeps an old value
	always_comb
	begin
		for (int k = 0; k < 9; k++)
			o_pin[k] = i_oe[k] ? i_o[k] : 1'b1;
	end
endmodule

// ---- verif/lpi_intensity_tb_top.sv ----
// self-checking bench for the pwm intensity block
`timescale 1ns/10ps
module lpi_intensity_tb_top;
	import lpi_pkg::*;
	// short step keeps one 240-step period at 960 clocks
	localparam int SC = 4;
	localparam int PER = 240 * SC;
	logic i_mclk = 1'b0;
	logic i_srst = 1'b1;
	logic i_wr_en = 1'b0;
	logic [7:0] i_wr_addr = 8'h00;
	logic [7:0] i_wr_data = 8'h00;
	logic i_rd_en = 1'b0;
	logic [7:0] i_rd_addr = 8'h00;
	logic [7:0] o_rd_data;
	logic i_global_en = 1'b0;
	logic [8:0] i_level = 9'h000;
	logic [8:0] o_port_o;
	logic [8:0] o_port_oe;
	logic o_pwm_run;
	logic [8:0] pin;
	logic [3:0] set_r [9];
	int errors = 0;
	int compares = 0;

	always #5 i_mclk = ~i_mclk;

	lpi_intensity #(.STEP_COUNT(SC), .OUT_N(9)) lpi_intensity_i (.i_mclk(i_mclk), .i_srst(i_srst),
		.i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en),
		.i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data), .i_global_en(i_global_en), .i_level(i_level),
		.o_port_o(o_port_o), .o_port_oe(o_port_oe), .o_pwm_run(o_pwm_run));
	lpi_pullup_load lpi_pullup_load_i (.i_oe(o_port_oe), .i_o(o_port_o), .o_pin(pin));

	////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_wr_en = 1'b1;
		i_wr_addr = a;
		i_wr_data = d;
		@(negedge i_mclk);
		i_wr_en = 1'b0;
		@(negedge i_mclk);
		// output intensity nibbles: low half is the even output
		if (a >= 8'h10 && a <= 8'h13)
		begin
			set_r[2 * (a - 8'h10)] = d[3:0];
			set_r[2 * (a - 8'h10) + 1] = d[7:4];
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		i_rd_en = 1'b1;
		i_rd_addr = a;
		@(negedge i_mclk);
		i_rd_en = 1'b0;
		@(negedge i_mclk);
		chk({8'h00, o_rd_data}, {8'h00, exp});
	endtask

	// low clocks of one pin over a whole period
	function automatic int exp_low(input logic [3:0] n, input logic lvl, input logic [3:0] m);
		if (n == 4'hf || m == 4'h0)
			return lvl ? 0 : PER;
		if (lvl)
			return m * (15 - n) * SC + (15 - m) * 16 * SC;
		return m * (n + 1) * SC;
	endfunction

	// any window of one period length is exact once the counters run
	task automatic measure(input logic [7:0] mg);
		int cnt [9];
		logic [3:0] n;
		cnt = '{default: 0};
		repeat (30) @(negedge i_mclk);
		repeat (PER)
		begin
			@(negedge i_mclk);
			for (int k = 0; k < 9; k++)
				if (pin[k] === 1'b0)
					cnt[k]++;
		end
		for (int k = 0; k < 9; k++)
		begin
			n = (i_global_en || k == 8) ? mg[3:0] : set_r[k];
			chk(cnt[k][15:0], 16'(exp_low(n, i_level[k], mg[7:4])));
		end
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(negedge i_mclk);
		i_srst = 1'b0;
		@(negedge i_mclk);
		for (int a = 8'h0e; a <= 8'h14; a++)
			rd(a[7:0], 8'h00);
		i_level = 9'h0a5;
		i_global_en = 1'b1;
		wr(8'h10, 8'he0);
		wr(8'h11, 8'hf7);
		wr(8'h12, 8'hd1);
		wr(8'h13, 8'h3f);
		rd(8'h12, 8'hd1);
		wr(8'h0e, 8'h0f);
		measure(8'h0f);
		chk({15'h0, o_pwm_run}, 16'h0000);
		i_global_en = 1'b0;
		wr(8'h0e, 8'h35);
		rd(8'h0e, 8'h35);
		// unmapped writes must leave every register alone
		wr(8'h0f, 8'hff);
		wr(8'h14, 8'h5a);
		rd(8'h0e, 8'h35);
		rd(8'h14, 8'h00);
		chk({15'h0, o_pwm_run}, 16'h0001);
		measure(8'h35);
		i_level = 9'h15a;
		measure(8'h35);
		// static and pwm outputs mixed, all pwm ones sharing one value, individual mode
		wr(8'h10, 8'h55);
		wr(8'h11, 8'h5f);
		wr(8'h12, 8'hf5);
		wr(8'h13, 8'h55);
		measure(8'h35);
		i_global_en = 1'b1;
		wr(8'h0e, 8'hf7);
		measure(8'hf7);
		wr(8'h0e, 8'hae);
		measure(8'hae);
		wr(8'h0e, 8'h0e);
		measure(8'h0e);
		// reset while the master field is zero restores every register and leaves pins static
		i_srst = 1'b1;
		repeat (2) @(negedge i_mclk);
		i_srst = 1'b0;
		@(negedge i_mclk);
		rd(8'h0e, 8'h00);
		rd(8'h10, 8'h00);
		rd(8'h13, 8'h00);
		chk({7'h00, pin}, {7'h00, i_level});
		close_out();
	end

	// whole sequence needs about 7000 clocks, well under the 40000-clock limit
	initial
	begin
		#400000;
		errors++;
		close_out();
	end
endmodule
